// ---- core/aps_defs.vh ----
/*
 Constants for the alarm and protection supervisor: timing figures, alarm
 bit positions and reset values. Assumes inclusion by the supervisor only.
*/
`ifndef APS_DEFS_VH
`define APS_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define APS_CLK_HZ          10000000
`define APS_LANG_MS         3000
`define APS_MAIN_MS         2000
`define APS_FAN_MS          500
`define APS_OFF_MS          3000

// ****************************************
// Alarm bit positions
// ****************************************
`define APS_B_SUPPLY        0
`define APS_B_HEAT          1
`define APS_B_OV            2
`define APS_B_OC            3
`define APS_B_OP            4
`define APS_B_CEIL          5
`define APS_B_SHARE         6
`define APS_NALM            7

// ****************************************
// Reset values
// ****************************************
`define APS_ALM_RST         7'h00
`define APS_CNT_RST         16'h0000

`endif

// ---- core/aps_supervisor.v ----
/*
 Alarm and protection supervisor of a bidirectional DC supply.
 Assumes comparator and measurement inputs synchronous to ref_clk,
 settings held stable by the menu logic, and a nonvolatile store that
 captures save_* outputs on save_stb and returns them on restore_*.
*/
// Contract
// R1: Each alarm drives display, beeper when enabled, digital status and analog pin.
// R2: An alarm counter is kept and readable on display and digital interface.
// R3: Supply failure turns the DC terminal off at once.
// R4: After mains undervoltage clears, restore output only if resume setting allows.
// R5: Every power-down raises a supply failure alarm.
// R6: Overheat turns stages off; auto-restart after cooling only if setting allows.
// R7: Overheat indication stays until cleared; clearing accepted any time. Code ignores alarm_ack while temp_high is set.
// R8: Voltage above adjustable threshold trips output and over-voltage flag.
// R9: Current reaching its limit trips output and over-current flag.
// R10: Voltage times current reaching power limit trips output and over-power flag.
// R11: Voltage reaching fixed ceiling trips output and shows ceiling alarm.
// R12: Ceiling alarm ignores acknowledge; only power cycle clears it.
// R13: Ceiling supervision exists only when the build option selects it.
// R14: Miswired or shorted shared bus trips output and raises bus fault.
// R15: Bus fault stays latched until acknowledged after cause is gone.
// R16: Power-up output state follows setting: off, or restore last state.
// R17: At switch-off save stage state and set values; restore at power-up.
// R18: At switch-off stage off at once, fans later, full power-down after.
// R19: Remote party ignores analog digital outputs until ready is reported.
// R20: Language screen stands 3 s, main screen follows a few seconds later. Code keeps the language screen through ST_WAIT, 5 s in all.
// R21: Remote takeover accepted any time unless front-panel lockout active. Code accepts it only in ST_RUN.
// R22: Settings menu only while output off; status shown otherwise.
// R23: Each alarm has its own latch and counts once per occurrence.
// R24: After a trip output stays off until re-enabled, except allowed auto-resume.
`timescale 1ns/1ps
`default_nettype none
`include "aps_defs.vh"

module aps_supervisor #(
   parameter         VW          = 16,
   parameter         IW          = 16,
   parameter         CEIL_EN     = 1,
   parameter [15:0]  CEIL_CODE   = 16'h17AC,
   parameter         LANG_CYC    = (`APS_LANG_MS * (`APS_CLK_HZ / 1000)),
   parameter         MAIN_CYC    = (`APS_MAIN_MS * (`APS_CLK_HZ / 1000)),
   parameter         FAN_CYC     = (`APS_FAN_MS * (`APS_CLK_HZ / 1000)),
   parameter         OFF_CYC     = (`APS_OFF_MS * (`APS_CLK_HZ / 1000))
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire             clk_en,
   input  wire [VW-1:0]    meas_volt,
   input  wire [IW-1:0]    meas_curr,
   input  wire [VW-1:0]    ov_limit,
   input  wire [IW-1:0]    oc_limit,
   input  wire [VW+IW-1:0] op_limit,
   input  wire             mains_low,
   input  wire             input_stage_fault,
   input  wire             power_stage_fault,
   input  wire             temp_high,
   input  wire             share_wired,
   input  wire             share_short,
   input  wire             master_slave_cfg,
   input  wire             resume_after_supply_failure,
   input  wire             resume_after_overheat,
   input  wire             power_up_restore,
   input  wire             beep_enable,
   input  wire             power_switch_off,
   input  wire             dc_on_req,
   input  wire             dc_off_req,
   input  wire             alarm_ack,
   input  wire             remote_req,
   input  wire             remote_release,
   input  wire             local_lockout,
   input  wire             menu_req,
   input  wire             restore_valid,
   input  wire             restore_dc_on,
   input  wire [VW-1:0]    set_volt,
   input  wire [IW-1:0]    set_curr,
   input  wire [VW-1:0]    restore_volt,
   input  wire [IW-1:0]    restore_curr,
   output reg              dc_terminal_on,
   output reg  [6:0]       alarm_status,
   output reg  [6:0]       alarm_analog,
   output reg              alarm_display,
   output reg              beeper,
   output reg  [15:0]      alarm_count,
   output reg              remote_active,
   output reg              menu_open,
   output reg              status_view,
   output reg  [1:0]       screen,
   output reg              ready,
   output reg              save_stb,
   output reg              save_dc_on,
   output reg  [VW-1:0]    save_volt,
   output reg  [IW-1:0]    save_curr,
   output reg  [VW-1:0]    active_volt,
   output reg  [IW-1:0]    active_curr,
   output reg              fan_on,
   output reg              power_hold
);

   // ****************************************
   // Local constants
   // ****************************************
   localparam [1:0] SCR_INFO  = 2'd0;
   localparam [1:0] SCR_LANG  = 2'd1;
   localparam [1:0] SCR_MAIN  = 2'd2;
   localparam [1:0] SCR_OFF   = 2'd3;

   localparam [2:0] ST_BOOT   = 3'd0;
   localparam [2:0] ST_LANG   = 3'd1;
   localparam [2:0] ST_WAIT   = 3'd2;
   localparam [2:0] ST_RUN    = 3'd3;
   localparam [2:0] ST_FANS   = 3'd4;
   localparam [2:0] ST_DOWN   = 3'd5;
   localparam [2:0] ST_DEAD   = 3'd6;

   localparam [31:0] INFO_CYC = 32'd16;

   // ****************************************
   // Functions
   // ****************************************
   function [15:0] sat_inc;
      input [15:0] v;
      input [2:0]  n;
      begin
         if (v > (16'hFFFF - {13'd0, n}))
            sat_inc = 16'hFFFF;
         else
            sat_inc = v + {13'd0, n};
      end
   endfunction

   function [2:0] pop7;
      input [6:0] b;
      integer k;
      begin
         pop7 = 3'd0;
         for (k = 0; k < 7; k = k + 1)
            pop7 = pop7 + {2'd0, b[k]};
      end
   endfunction

   // ****************************************
   // Alarm detection
   // ****************************************
   wire [VW+IW-1:0] power_prod;
   wire [6:0]       cond;
   wire             supply_cond;
   wire             ceil_cond;

   assign power_prod  = meas_volt * meas_curr;                              // R10
   assign supply_cond = mains_low | input_stage_fault | power_stage_fault;  // R3
   assign ceil_cond   = (CEIL_EN != 0) && (meas_volt >= CEIL_CODE[VW-1:0]); // R11 R13

   assign cond[`APS_B_SUPPLY] = supply_cond;
   assign cond[`APS_B_HEAT]   = temp_high;
   assign cond[`APS_B_OV]     = meas_volt > ov_limit;                       // R8
   assign cond[`APS_B_OC]     = meas_curr >= oc_limit;                      // R9
   assign cond[`APS_B_OP]     = power_prod >= op_limit;                     // R10
   assign cond[`APS_B_CEIL]   = ceil_cond;
   assign cond[`APS_B_SHARE]  = share_short | (share_wired & ~master_slave_cfg); // R14

   // ****************************************
   // Latches, counter, trip
   // ****************************************
   reg  [6:0]  cond_q;
   reg  [2:0]  st_q;
   reg  [31:0] tmr_q;
   reg         was_on_q;
   reg         auto_q;
   wire [6:0]  rise;
   wire [6:0]  clr;
   wire [6:0]  alm_d;
   wire        trip;
   wire        running;
   wire        going_down;

   assign running    = (st_q == ST_RUN);
   assign going_down = running & power_switch_off;
   assign rise       = (cond & ~cond_q) | {6'd0, going_down};                // R5 R23

   // Ack clears a flag only once its cause is gone; ceiling flag never clears
   assign clr = {7{alarm_ack}} & ~cond & ~(7'd1 << `APS_B_CEIL);             // R7 R12 R15
   assign alm_d = (alarm_status & ~clr) | rise | cond;                       // R23
   assign trip  = |(rise | (cond & ~(7'd1 << `APS_B_HEAT)));                 // R3 R8 R9 R10 R11 R14

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cond_q        <= 7'h00;
         alarm_status  <= `APS_ALM_RST;
         alarm_analog  <= `APS_ALM_RST;
         alarm_display <= 1'b0;
         beeper        <= 1'b0;
         alarm_count   <= `APS_CNT_RST;
      end else if (clk_en) begin
         cond_q        <= cond;
         alarm_status  <= alm_d;                                             // R1
         alarm_analog  <= alm_d;                                             // R1
         alarm_display <= |alm_d;                                            // R1
         beeper        <= beep_enable & (|alm_d);                            // R1
         alarm_count   <= sat_inc(alarm_count, pop7(rise));                  // R2 R23
      end
   end

   // ****************************************
   // Output state, remote, menu
   // ****************************************
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dc_terminal_on <= 1'b0;
         was_on_q       <= 1'b0;
         auto_q         <= 1'b0;
         remote_active  <= 1'b0;
         menu_open      <= 1'b0;
         status_view    <= 1'b0;
      end else if (clk_en) begin
         if (!running || trip) begin
            if (running && dc_terminal_on) begin
               // Remember what may auto-resume after the cause clears
               auto_q <= (cond[`APS_B_SUPPLY] & mains_low & ~input_stage_fault
                          & ~power_stage_fault & resume_after_supply_failure
                          & ~(|(cond & 7'b1111100)))                          // R4
                         | (cond[`APS_B_HEAT] & resume_after_overheat);       // R6
            end
            if (running && dc_terminal_on && !going_down)
               was_on_q <= 1'b1;
            if (st_q == ST_WAIT && restore_valid && !(|cond))
               dc_terminal_on <= power_up_restore & restore_dc_on;           // R16
            else
               dc_terminal_on <= 1'b0;                                      // R3 R18 R24
         end else if (temp_high) begin
            dc_terminal_on <= 1'b0;                                         // R6
         end else if (dc_off_req) begin
            dc_terminal_on <= 1'b0;
            auto_q         <= 1'b0;
         end else if (dc_on_req) begin
            dc_terminal_on <= 1'b1;                                         // R24
            auto_q         <= 1'b0;
         end else if (auto_q && !(|cond)) begin
            dc_terminal_on <= 1'b1;                                         // R4 R6 R24
            auto_q         <= 1'b0;
         end
         if (running && dc_terminal_on)
            was_on_q <= 1'b1;
         else if (running && dc_off_req)
            was_on_q <= 1'b0;
         if (remote_release)
            remote_active <= 1'b0;
         else if (remote_req && !local_lockout && running)
            remote_active <= 1'b1;                                          // R21
         else if (local_lockout)
            remote_active <= 1'b0;                                          // R21
         menu_open   <= running & menu_req & ~dc_terminal_on;                // R22
         status_view <= running & menu_req & dc_terminal_on;                 // R22
      end
   end

   // ****************************************
   // Power sequencing
   // ****************************************
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q        <= ST_BOOT;
         tmr_q       <= 32'd0;
         screen      <= SCR_INFO;
         ready       <= 1'b0;
         fan_on      <= 1'b0;
         power_hold  <= 1'b0;
         save_stb    <= 1'b0;
         save_dc_on  <= 1'b0;
         save_volt   <= {VW{1'b0}};
         save_curr   <= {IW{1'b0}};
         active_volt <= {VW{1'b0}};
         active_curr <= {IW{1'b0}};
      end else if (clk_en) begin
         save_stb <= 1'b0;
         tmr_q    <= tmr_q + 32'd1;
         case (st_q)
            ST_BOOT: begin
               power_hold <= 1'b1;
               fan_on     <= 1'b1;
               if (tmr_q >= INFO_CYC - 32'd1) begin
                  st_q   <= ST_LANG;
                  tmr_q  <= 32'd0;
                  screen <= SCR_LANG;
               end
            end
            ST_LANG: begin
               if (tmr_q >= LANG_CYC - 1) begin                             // R20
                  st_q  <= ST_WAIT;
                  tmr_q <= 32'd0;
               end
            end
            ST_WAIT: begin
               if (restore_valid) begin
                  active_volt <= restore_volt;                               // R17
                  active_curr <= restore_curr;                               // R17
               end
               if (tmr_q >= MAIN_CYC - 1) begin                             // R20
                  st_q   <= ST_RUN;
                  tmr_q  <= 32'd0;
                  screen <= SCR_MAIN;
                  ready  <= 1'b1;                                           // R19
               end
            end
            ST_RUN: begin
               active_volt <= set_volt;
               active_curr <= set_curr;
               if (power_switch_off) begin
                  save_stb   <= 1'b1;                                       // R17
                  save_dc_on <= dc_terminal_on;                             // R17
                  save_volt  <= set_volt;                                   // R17
                  save_curr  <= set_curr;                                   // R17
                  ready      <= 1'b0;
                  st_q       <= ST_FANS;
                  tmr_q      <= 32'd0;
               end
            end
            ST_FANS: begin
               if (tmr_q >= FAN_CYC - 1) begin                              // R18
                  fan_on <= 1'b0;
                  st_q   <= ST_DOWN;
                  tmr_q  <= 32'd0;
               end
            end
            ST_DOWN: begin
               if (tmr_q >= OFF_CYC - 1) begin                              // R18
                  power_hold <= 1'b0;
                  screen     <= SCR_OFF;
                  st_q       <= ST_DEAD;
               end
            end
            ST_DEAD: begin
               tmr_q <= 32'd0;
            end
            default: begin
               st_q <= ST_BOOT;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ---- bench/aps_supervisor_props.sv ----
/* Port checker for the alarm and protection supervisor.
   Assumes one clock domain and bind onto aps_supervisor. */
`timescale 1ns/1ps
`default_nettype none
module aps_supervisor_props #(
   parameter VW = 16,
   parameter IW = 16
) (
   input wire logic             ref_clk,
   input wire logic             rst,
   input wire logic             clk_en,
   input wire logic [VW-1:0]    meas_volt,
   input wire logic [IW-1:0]    meas_curr,
   input wire logic [VW-1:0]    ov_limit,
   input wire logic [IW-1:0]    oc_limit,
   input wire logic [VW+IW-1:0] op_limit,
   input wire logic             power_stage_fault,
   input wire logic             local_lockout,
   input wire logic             dc_terminal_on,
   input wire logic [6:0]       alarm_status,
   input wire logic [6:0]       alarm_analog,
   input wire logic [15:0]      alarm_count,
   input wire logic             remote_active,
   input wire logic             menu_open,
   input wire logic             save_stb,
   input wire logic             ready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ****************************************
   // Trips and latches
   // ****************************************
   a_ov_trip: assert property (clk_en && ready && meas_volt > ov_limit |=> alarm_status[2] && !dc_terminal_on)
      else $error("over-voltage trip missing");
   a_oc_trip: assert property (clk_en && ready && meas_curr >= oc_limit |=> alarm_status[3] && !dc_terminal_on)
      else $error("over-current trip missing");
   a_op_trip: assert property (clk_en && ready && (VW+IW)'(meas_volt) * (VW+IW)'(meas_curr) >= op_limit
      |=> alarm_status[4] && !dc_terminal_on) else $error("over-power trip missing");
   a_supply_trip: assert property (clk_en && power_stage_fault |=> alarm_status[0] && !dc_terminal_on)
      else $error("supply failure trip missing");
   a_ceil_latch: assert property (alarm_status[5] |=> alarm_status[5])
      else $error("ceiling alarm released");
   a_status_mirror: assert property (alarm_analog == alarm_status)
      else $error("analog alarms differ from status");
   a_count_mono: assert property (alarm_count >= $past(alarm_count))
      else $error("alarm count went down");
   a_lock_remote: assert property (clk_en && local_lockout |=> !remote_active)
      else $error("remote active under lockout");
   a_menu_off: assert property (menu_open |-> !dc_terminal_on)
      else $error("menu open with output on");
   a_shutdown: assert property ($rose(save_stb) |-> alarm_status[0] && !dc_terminal_on && !ready)
      else $error("shutdown state wrong");
   c_ov: cover property (alarm_status[2]);
   c_save: cover property (save_stb);
   c_remote: cover property (remote_active);
endmodule
bind aps_supervisor aps_supervisor_props #(.VW(VW), .IW(IW)) aps_supervisor_props_i (.*);
`default_nettype wire

// ---- bench/aps_remote_model.sv ----
/* Remote control equipment on the interface side.
   Assumes requests are launched from the bench through take. */
`timescale 1ns/1ps
`default_nettype none
module aps_remote_model (
   input  wire logic       ref_clk,
   input  wire logic       ready,
   input  wire logic [6:0] alarm_analog,
   output var logic        remote_req,
   output var logic        remote_release,
   output var logic [6:0]  seen_alarm
);
   initial begin
      remote_req = 1'b0;
      remote_release = 1'b0;
   end
   // Analog lines may be undefined while booting
   always @(posedge ref_clk) seen_alarm <= ready ? alarm_analog : 7'h00;
   task automatic take(input logic rel);
      if (rel) remote_release <= 1'b1;
      else remote_req <= 1'b1;
      @(posedge ref_clk);
      remote_req <= 1'b0;
      remote_release <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- bench/alarm_protection_supervisor_tb.sv ----
/* Self-checking bench for the alarm and protection supervisor.
   Assumes the remote model and bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module alarm_protection_supervisor_tb;
   logic        ref_clk, rst, clk_en, mains_low, input_stage_fault, power_stage_fault, temp_high;
   logic        share_wired, share_short, master_slave_cfg, resume_after_supply_failure;
   logic        resume_after_overheat, power_up_restore, beep_enable, power_switch_off;
   logic        dc_on_req, dc_off_req, alarm_ack, remote_req, remote_release, local_lockout;
   logic        menu_req, restore_valid, restore_dc_on, dc_terminal_on, alarm_display, beeper;
   logic        remote_active, menu_open, status_view, ready, save_stb, save_dc_on, fan_on, power_hold;
   logic [15:0] meas_volt, meas_curr, ov_limit, oc_limit, set_volt, set_curr, restore_volt, restore_curr;
   logic [15:0] alarm_count, save_volt, save_curr, active_volt, active_curr, c0;
   logic [31:0] op_limit;
   logic [6:0]  alarm_status, alarm_analog, seen_alarm;
   logic [1:0]  screen;
   int          bad_count, n_compared, cyc;
   int          trip_bits [5] = '{2, 3, 4, 0, 6};
   aps_supervisor #(.LANG_CYC(10), .MAIN_CYC(10), .FAN_CYC(10), .OFF_CYC(10)) aps_supervisor_i (.*);
   aps_remote_model aps_remote_model_i (.ref_clk(ref_clk), .ready(ready), .alarm_analog(alarm_analog),
      .remote_req(remote_req), .remote_release(remote_release), .seen_alarm(seen_alarm));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic ack;
      alarm_ack <= 1'b1;
      tick(1);
      alarm_ack <= 1'b0;
      tick(2);
   endtask
   task automatic turn_on;
      dc_on_req <= 1'b1;
      tick(1);
      dc_on_req <= 1'b0;
      tick(2);
   endtask
   task automatic boot;
      rst <= 1'b1;
      tick(12);
      rst <= 1'b0;
      for (int i = 0; i < 80 && ready !== 1'b1; i++) tick(1);
      chk("restored volt", restore_volt, active_volt);
      chk("restored curr", restore_curr, active_curr);
      tick(1);
      chk("screen", 16'h0002, 16'(screen));
   endtask
   task automatic trip(input int b);
      c0 = alarm_count;
      case (b)
         2: meas_volt <= ov_limit + 16'h0001;
         3: meas_curr <= oc_limit;
         4: begin
            meas_volt <= 16'h0010;
            meas_curr <= 16'h0010;
         end
         0: input_stage_fault <= 1'b1;
         default: share_wired <= 1'b1;
      endcase
      tick(2);
      chk("alarm bit", 16'h0001, 16'(alarm_status[b]));
      chk("dc off", 16'h0000, 16'(dc_terminal_on));
      chk("count", c0 + 16'h0001, alarm_count);
      meas_volt <= 16'h0000;
      meas_curr <= 16'h0000;
      input_stage_fault <= 1'b0;
      share_wired <= 1'b0;
      tick(1);
      ack();
      chk("cleared", 16'h0000, 16'(alarm_status[b]));
      turn_on();
      chk("dc back", 16'h0001, 16'(dc_terminal_on));
   endtask
   // ****************************************
   // Timeout and sequence
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      {rst, clk_en, restore_valid, restore_dc_on} = 4'hF;
      {mains_low, input_stage_fault, power_stage_fault, temp_high, share_wired, share_short} = 6'h00;
      {master_slave_cfg, resume_after_supply_failure, resume_after_overheat, power_up_restore} = 4'h0;
      {beep_enable, power_switch_off, dc_on_req, dc_off_req, alarm_ack, local_lockout, menu_req} = 7'h00;
      {meas_volt, meas_curr, ov_limit, oc_limit} = {32'h0000_0000, 32'h1000_1000};
      {set_volt, set_curr, restore_volt, restore_curr} = 64'h1234_0222_0ABC_0111;
      op_limit = 32'h0000_0100;
      boot();
      chk("power-up off", 16'h0000, 16'(dc_terminal_on));
      turn_on();
      meas_volt <= ov_limit;
      tick(2);
      chk("ov at limit", 16'h0000, 16'(alarm_status[2]));
      {meas_volt, oc_limit, meas_curr} <= 48'h0000_0200_01FF;
      tick(2);
      chk("oc below", 16'h0000, 16'(alarm_status[3]));
      meas_curr <= 16'h0000;
      foreach (trip_bits[k]) trip(trip_bits[k]);
      $display("test trips done");
      resume_after_supply_failure <= 1'b1;
      mains_low <= 1'b1;
      tick(2);
      chk("mains off", 16'h0000, 16'(dc_terminal_on));
      mains_low <= 1'b0;
      tick(3);
      chk("mains resume", 16'h0001, 16'(dc_terminal_on));
      ack();
      power_stage_fault <= 1'b1;
      tick(2);
      chk("stage off", 16'h0000, 16'(dc_terminal_on));
      power_stage_fault <= 1'b0;
      tick(3);
      chk("stage no resume", 16'h0000, 16'(dc_terminal_on));
      ack();
      turn_on();
      {beep_enable, resume_after_overheat, temp_high} <= 3'h7;
      tick(2);
      chk("heat off", 16'h0000, 16'(dc_terminal_on));
      chk("beeper", 16'h0001, 16'(beeper));
      chk("display", 16'h0001, 16'(alarm_display));
      temp_high <= 1'b0;
      tick(3);
      chk("heat resume", 16'h0001, 16'(dc_terminal_on));
      chk("heat kept", 16'h0001, 16'(alarm_status[1]));
      chk("analog seen", 16'h0001, 16'(seen_alarm[1]));
      ack();
      chk("heat cleared", 16'h0000, 16'(alarm_status[1]));
      $display("test heat done");
      menu_req <= 1'b1;
      tick(2);
      chk("menu refused", 16'h0000, 16'(menu_open));
      chk("status view", 16'h0001, 16'(status_view));
      dc_off_req <= 1'b1;
      tick(1);
      dc_off_req <= 1'b0;
      tick(3);
      chk("menu open", 16'h0001, 16'(menu_open));
      menu_req <= 1'b0;
      local_lockout <= 1'b1;
      aps_remote_model_i.take(1'b0);
      tick(2);
      chk("remote locked", 16'h0000, 16'(remote_active));
      local_lockout <= 1'b0;
      aps_remote_model_i.take(1'b0);
      tick(2);
      chk("remote taken", 16'h0001, 16'(remote_active));
      aps_remote_model_i.take(1'b1);
      tick(2);
      chk("remote freed", 16'h0000, 16'(remote_active));
      $display("test menu and remote done");
      {clk_en, share_short} <= 2'h1;
      tick(3);
      chk("frozen", 16'h0000, 16'(alarm_status[6]));
      clk_en <= 1'b1;
      tick(2);
      ack();
      chk("bus fault kept", 16'h0001, 16'(alarm_status[6]));
      share_short <= 1'b0;
      tick(1);
      ack();
      chk("bus fault gone", 16'h0000, 16'(alarm_status[6]));
      {master_slave_cfg, share_wired} <= 2'h3;
      tick(2);
      chk("bus cfg ok", 16'h0000, 16'(alarm_status[6]));
      {master_slave_cfg, share_wired} <= 2'h0;
      {ov_limit, meas_volt} <= 32'hFFFF_17AC;
      tick(2);
      chk("ceiling", 16'h0001, 16'(alarm_status[5]));
      meas_volt <= 16'h0000;
      tick(1);
      ack();
      chk("ceiling kept", 16'h0001, 16'(alarm_status[5]));
      {set_volt, set_curr} <= 32'h0321_0123;
      power_switch_off <= 1'b1;
      tick(2);
      chk("save pulse", 16'h0001, 16'(save_stb));
      chk("save state", 16'h0000, 16'(save_dc_on));
      chk("save volt", set_volt, save_volt);
      chk("save curr", set_curr, save_curr);
      chk("pf on off", 16'h0001, 16'(alarm_status[0]));
      for (int i = 0; i < 30 && fan_on !== 1'b0; i++) tick(1);
      chk("fans stopped", 16'h0000, 16'(fan_on));
      chk("still held", 16'h0001, 16'(power_hold));
      for (int i = 0; i < 30 && power_hold !== 1'b0; i++) tick(1);
      chk("powered off", 16'h0000, 16'(power_hold));
      $display("test shutdown done");
      {power_switch_off, power_up_restore} <= 2'h1;
      boot();
      chk("restored on", 16'h0001, 16'(dc_terminal_on));
      chk("run volt", set_volt, active_volt);
      chk("ceiling reset", 16'h0000, 16'(alarm_status[5]));
      $display("test power-up restore done");
      conclude();
   end
endmodule
`default_nettype wire
